// ---- verilog/fprf_pkg.sv ----
// Package of constants and types for the floating-point register file and state register.
// Functional notes
// - File holds 32 single, 16 double, 8 quad.
// - Double uses even register and next one.
// - Quad uses four registers from multiple of four.
// - Source keeps double specifier low bit zero.
// - Source keeps quad specifier two low bits zero.
// - Misaligned operand raises trap with code six.
// - State register fields sit at fixed positions.
// - Store-state reads, load-state writes state register.
// - Rounding field selects nearest, zero, plus, minus.
// - Software writes zeros into unused bits.
// - Enabled exception traps; disabled one does not.
// - Nonstandard bit allows implementation-defined results.
// - Reserved bits read zero, written zero.
// - Version field identifies unit; seven means none.
// - Trap type holds until store-state or operate; here a misaligned data access also sets it to six.
// - Load-state leaves trap type unchanged.
// - Store-state clear optional; handler ensures zero.
// - Trap type codes zero to six, seven reserved.
// - Thirty-two registers, all reachable without windowing.
package fprf_pkg;

  localparam int NUM_REGS = 32;
  localparam int REG_W    = 32;
  localparam int IDX_W    = 5;

  // State register field positions.
  localparam int RND_HI = 31;
  localparam int RND_LO = 30;
  localparam int TEM_HI = 27;
  localparam int TEM_LO = 23;
  localparam int NS_BIT = 22;
  localparam int VER_HI = 19;
  localparam int VER_LO = 17;
  localparam int TT_HI  = 16;
  localparam int TT_LO  = 14;
  localparam int QNE_BIT = 13;
  localparam int CC_HI  = 11;
  localparam int CC_LO  = 10;
  localparam int AEX_HI = 9;
  localparam int AEX_LO = 5;
  localparam int CEX_HI = 4;
  localparam int CEX_LO = 0;

  // Bits that load-state may write: rounding, enables, nonstandard, cc, accrued, current.
  localparam logic [31:0] LOAD_MASK  = 32'hCFC00FFF;
  localparam logic [31:0] STATE_RST  = 32'h00000000;
  // Version code of this unit; the value is arbitrary.
  localparam logic [2:0]  VERSION    = 3'h1;

  // APB register map of the controller end.
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_WDATA  = 8'h04;
  localparam logic [7:0] ADDR_RDATA  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ    = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [31:0] APB_RST    = 32'h00000000;

  // Command field layout in the command register.
  localparam int CMD_OP_HI  = 3;
  localparam int CMD_OP_LO  = 0;
  localparam int CMD_IDX_HI = 8;
  localparam int CMD_IDX_LO = 4;
  localparam int CMD_EXC_HI = 14;
  localparam int CMD_EXC_LO = 10;
  localparam int CMD_CC_HI  = 16;
  localparam int CMD_CC_LO  = 15;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_ZERO    = 2'h1,
    RND_PINF    = 2'h2,
    RND_NINF    = 2'h3
  } fprf_rnd_t;

  typedef enum logic [2:0] {
    TT_NONE      = 3'h0,
    TT_STANDARD  = 3'h1,
    TT_UNFINISH  = 3'h2,
    TT_UNIMPL    = 3'h3,
    TT_SEQUENCE  = 3'h4,
    TT_HARDWARE  = 3'h5,
    TT_MISALIGN  = 3'h6,
    TT_RESERVED  = 3'h7
  } fprf_tt_t;

  // Operations the integer unit issues.
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_RD_S   = 4'h1,
    OP_WR_S   = 4'h2,
    OP_RD_D   = 4'h3,
    OP_WR_D   = 4'h4,
    OP_RD_Q   = 4'h5,
    OP_WR_Q   = 4'h6,
    OP_STORE  = 4'h7,
    OP_LOAD   = 4'h8,
    OP_FOP    = 4'h9
  } fprf_op_t;

  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRAP = 1;
  localparam int IRQ_MIS  = 2;

endpackage

// ---- verilog/fprf_if.sv ----
// Interface joining the integer-unit controller and the floating-point register block.
`timescale 1ns/1ps
interface fprf_if;
  import fprf_pkg::*;
  logic        req;
  fprf_op_t    op;
  logic [4:0]  idx;
  logic [31:0] wdata;
  logic [4:0]  exc;
  logic [1:0]  cc;
  logic        ack;
  logic [31:0] rdata;
  logic        trap;
  fprf_tt_t    trap_type;

  modport dev  (input req, op, idx, wdata, exc, cc, output ack, rdata, trap, trap_type);
  modport ctrl (output req, op, idx, wdata, exc, cc, input ack, rdata, trap, trap_type);
endinterface

// ---- verilog/fprf_regs.sv ----
// Operand register array: thirty-two 32-bit words, one write and one read port.
`timescale 1ns/1ps
module fprf_regs
  import fprf_pkg::*;
(
  // Clock.
  input  wire logic        pclk,
  // Write port.
  input  wire logic        we,
  input  wire logic [4:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read port.
  input  wire logic [4:0]  raddr,
  output      logic [31:0] rdata
);
  // Every word is directly addressable; there is no windowing.
  logic [REG_W-1:0] mem [NUM_REGS];

  // The array carries no reset so that it can map onto plain RAM.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // fprf_regs

// ---- verilog/fprf_dev.sv ----
// Floating-point register file and state register end of the link.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module fprf_dev
  import fprf_pkg::*;
(
  // Clock and reset.
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Link to the controller.
  fprf_if.dev         lnk,
  // Mode outputs to the arithmetic datapath.
  output      logic [1:0] rnd_mode,
  output      logic       nonstd_mode
);
  import fprf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Operand sequencing. Doubles and quads move one word per beat.

  typedef enum {S_IDLE, S_BEAT, S_DONE} fprf_dst_t;
  fprf_dst_t   st_r, st_nxt;
  logic [1:0]  beat_r;
  logic [1:0]  last_w;
  logic        misal_w;
  logic        is_wr_w;
  logic        is_data_w;
  logic [4:0]  addr_w;
  logic [31:0] rd_w;
  logic [31:0] rdata_r;
  logic [31:0] state_r;
  logic        ack_r;
  logic        trap_r;
  fprf_tt_t    tt_w;

  // Double needs bit 0 clear, quad bits 1:0 clear.
  assign misal_w = ((lnk.op == OP_RD_D || lnk.op == OP_WR_D) && lnk.idx[0]) ||
                   ((lnk.op == OP_RD_Q || lnk.op == OP_WR_Q) && (lnk.idx[1:0] != 2'h0));
  assign last_w  = (lnk.op == OP_RD_Q || lnk.op == OP_WR_Q) ? 2'h3 :
                   (lnk.op == OP_RD_D || lnk.op == OP_WR_D) ? 2'h1 : 2'h0;
  assign is_wr_w = (lnk.op == OP_WR_S || lnk.op == OP_WR_D || lnk.op == OP_WR_Q);
  assign is_data_w = is_wr_w || lnk.op == OP_RD_S || lnk.op == OP_RD_D || lnk.op == OP_RD_Q;
  // Word k of an operand lives at base plus k: high word first.
  assign addr_w  = lnk.idx + {3'h0, beat_r};

  fprf_regs u_regs (
    .pclk  (pclk),
    .we    (st_r == S_BEAT && is_wr_w && !misal_w),
    .waddr (addr_w),
    .wdata (lnk.wdata),
    .raddr (addr_w),
    .rdata (rd_w)
  );

  // Each beat answers with ack; the controller holds req until the last beat.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (lnk.req) st_nxt = S_BEAT;
      S_BEAT: if (!is_data_w || misal_w || beat_r == last_w) st_nxt = S_DONE;
      S_DONE: if (!lnk.req) st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= S_IDLE;
      beat_r <= 2'h0;
    end else begin
      st_r   <= st_nxt;
      beat_r <= (st_r == S_BEAT && is_data_w && !misal_w && beat_r != last_w) ? beat_r + 2'h1 :
                (st_r == S_BEAT) ? beat_r : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  logic [4:0]  trig_w;
  logic        fop_w, store_w, load_w;
  logic [31:0] state_nxt;
  logic [31:0] view_w;

  assign fop_w   = st_r == S_BEAT && lnk.op == OP_FOP;
  assign store_w = st_r == S_BEAT && lnk.op == OP_STORE;
  assign load_w  = st_r == S_BEAT && lnk.op == OP_LOAD;
  // An exception traps only where its enable bit is set.
  assign trig_w  = lnk.exc & state_r[TEM_HI:TEM_LO];
  assign tt_w    = (st_r == S_BEAT && misal_w) ? TT_MISALIGN :
                   (fop_w && trig_w != 5'h0)   ? TT_STANDARD : TT_NONE;

  // Reserved, unused and version bits are built at read time, never stored.
  assign view_w = {state_r[31:30], 2'h0, state_r[27:22], 2'h0, VERSION,
                   state_r[16:14], 1'b0, 1'b0, state_r[11:0]};

  always_comb begin
    state_nxt = state_r;
    if (load_w) begin
      // Trap type and queue bit are not writable here.
      state_nxt = (lnk.wdata & LOAD_MASK) | (state_r & ~LOAD_MASK);
    end else if (store_w) begin
      state_nxt[TT_HI:TT_LO] = TT_NONE;
    end else if (tt_w != TT_NONE) begin
      state_nxt[TT_HI:TT_LO] = tt_w;
      if (tt_w == TT_STANDARD) begin
        state_nxt[CEX_HI:CEX_LO] = lnk.exc;
      end
    end else if (fop_w) begin
      // Untrapped operate clears trap type, posts exceptions and codes.
      state_nxt[TT_HI:TT_LO]   = TT_NONE;
      state_nxt[CEX_HI:CEX_LO] = lnk.exc;
      state_nxt[AEX_HI:AEX_LO] = state_r[AEX_HI:AEX_LO] | lnk.exc;
      state_nxt[CC_HI:CC_LO]   = lnk.cc;
    end
  end

  // Read data and answers are registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= STATE_RST;
      rdata_r <= 32'h00000000;
      ack_r   <= 1'b0;
      trap_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rdata_r <= store_w ? view_w : (st_r == S_BEAT ? rd_w : rdata_r);
      ack_r   <= st_r == S_BEAT;
      trap_r  <= st_r == S_BEAT && tt_w != TT_NONE;
    end
  end

  assign lnk.ack       = ack_r;
  assign lnk.rdata     = rdata_r;
  assign lnk.trap      = trap_r;
  assign lnk.trap_type = fprf_tt_t'(state_r[TT_HI:TT_LO]);
  assign rnd_mode      = state_r[RND_HI:RND_LO];
  assign nonstd_mode   = state_r[NS_BIT];
endmodule // fprf_dev

// ---- verilog/fprf_ctrl.sv ----
// Integer-unit end: APB registers that issue operations over the link.
`timescale 1ns/1ps
module fprf_ctrl
  import fprf_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Interrupt.
  output      logic        irq,
  // Link to the register block.
  fprf_if.ctrl             lnk
);
  import fprf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0] cmd_r, wdata_r, rdata_r;
  logic [IRQ_W-1:0] sts_r, mask_r;
  logic        busy_r;
  logic        wr_w, rd_w, hit_w;
  logic [IRQ_W-1:0] ev_w;
  logic [31:0] prdata_r;
  fprf_op_t    op_w;
  logic        ltrap_r;
  logic [1:0]  cnt_r;
  logic [1:0]  last_w;
  logic        start_w;
  logic        fin_w;

  assign wr_w  = psel && penable && pwrite;
  assign rd_w  = psel && penable && !pwrite;
  assign hit_w = paddr == ADDR_CMD || paddr == ADDR_WDATA || paddr == ADDR_RDATA ||
                 paddr == ADDR_STATUS || paddr == ADDR_IRQ || paddr == ADDR_MASK;
  assign op_w  = fprf_op_t'(cmd_r[CMD_OP_HI:CMD_OP_LO]);
  // Doubles and quads move two or four words, so req is held until the last word's ack.
  assign last_w  = (op_w == OP_RD_Q || op_w == OP_WR_Q) ? 2'h3 :
                   (op_w == OP_RD_D || op_w == OP_WR_D) ? 2'h1 : 2'h0;
  assign start_w = wr_w && paddr == ADDR_CMD && !busy_r;
  // A trap ends the operation at once, since the block stops after the trapping beat.
  assign fin_w   = lnk.ack && (lnk.trap || cnt_r == last_w);
  // Events: a beat finished, a trap reported, a misaligned specifier trapped.
  assign ev_w  = {lnk.ack && lnk.trap && lnk.trap_type == TT_MISALIGN,
                  lnk.ack && lnk.trap, lnk.ack && busy_r};

  // Writing the command register while idle starts an operation; req is held until the last ack or a trap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r   <= APB_RST;
      wdata_r <= APB_RST;
      rdata_r <= APB_RST;
      mask_r  <= '0;
      busy_r  <= 1'b0;
      cnt_r   <= 2'h0;
      ltrap_r <= 1'b0;
    end else begin
      if (start_w) cmd_r <= pwdata;
      if (wr_w && paddr == ADDR_WDATA) wdata_r <= pwdata;
      if (wr_w && paddr == ADDR_MASK) mask_r <= pwdata[IRQ_W-1:0];
      if (lnk.ack) rdata_r <= lnk.rdata;
      if (lnk.ack) ltrap_r <= lnk.trap;
      cnt_r  <= start_w ? 2'h0 : (lnk.ack ? cnt_r + 2'h1 : cnt_r);
      busy_r <= start_w ? 1'b1 : (fin_w ? 1'b0 : busy_r);
    end
  end

  // Set wins over the read-clear of the status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r    <= '0;
      prdata_r <= APB_RST;
    end else begin
      sts_r    <= ((rd_w && paddr == ADDR_IRQ) ? '0 : sts_r) | ev_w;
      prdata_r <= paddr == ADDR_CMD    ? cmd_r :
                  paddr == ADDR_WDATA  ? wdata_r :
                  paddr == ADDR_RDATA  ? rdata_r :
                  paddr == ADDR_STATUS ? {28'h0, lnk.trap_type == TT_NONE ? 1'b0 : 1'b1,
                                          ltrap_r, 1'b0, busy_r} :
                  paddr == ADDR_IRQ    ? {29'h0, sts_r} :
                  paddr == ADDR_MASK   ? {29'h0, mask_r} : 32'h00000000;
    end
  end

  // Specifier low bits pass as written; software keeps them clear for doubles and quads.
  assign lnk.req   = busy_r;
  assign lnk.op    = busy_r ? op_w : OP_NONE;
  assign lnk.idx   = cmd_r[CMD_IDX_HI:CMD_IDX_LO];
  assign lnk.wdata = op_w == OP_LOAD ? (wdata_r & LOAD_MASK) : wdata_r;
  assign lnk.exc   = cmd_r[CMD_EXC_HI:CMD_EXC_LO];
  assign lnk.cc    = cmd_r[CMD_CC_HI:CMD_CC_LO];

  assign pready  = psel && penable;
  assign prdata  = prdata_r;
  assign pslverr = psel && penable && !hit_w;
  assign irq     = |(sts_r & mask_r);
endmodule // fprf_ctrl

// ---- bench/fprf_chk.sv ----
// Checker on the link between controller and register block.
`timescale 1ns/1ps
module fprf_chk
  import fprf_pkg::*;
(
  // Clock and reset.
  input wire logic               pclk,
  input wire logic               presetn,
  // Link signals.
  input wire logic               req,
  input wire fprf_pkg::fprf_op_t op,
  input wire logic [4:0]         idx,
  input wire logic               ack,
  input wire logic [31:0]        rdata,
  input wire logic               trap,
  input wire fprf_pkg::fprf_tt_t trap_type
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Operand width classes, decoded once for the alignment checks.
  wire dbl = (op == OP_RD_D) || (op == OP_WR_D);
  wire qd  = (op == OP_RD_Q) || (op == OP_WR_Q);
  wire go  = req && !ack;
  ////////////////////////////////////////////////////////////
  a_ack_timing: assert property ($rose(req) |-> !ack ##1 !ack ##1 ack)
    else $error("ack not two cycles after request");
  a_ack_single: assert property (ack && !dbl && !qd |=> !ack)
    else $error("ack longer than one cycle");
  a_dbl_beats: assert property ($rose(req) && dbl && !idx[0] |-> ##2 ack [*2] ##1 !ack)
    else $error("double did not move two words");
  a_quad_beats: assert property ($rose(req) && qd && idx[1:0] == 2'h0 |-> ##2 ack [*4] ##1 !ack)
    else $error("quad did not move four words");
  a_trap_on_ack: assert property (trap |-> ack)
    else $error("trap without ack");
  a_dbl_misalign: assert property ($rose(req) && dbl && idx[0] |-> ##2 trap && trap_type == TT_MISALIGN)
    else $error("misaligned double not trapped");
  a_quad_misalign: assert property ($rose(req) && qd && idx[1:0] != 2'h0 |-> ##2 trap && trap_type == TT_MISALIGN)
    else $error("misaligned quad not trapped");
  a_store_reserved: assert property ($rose(req) && op == OP_STORE |-> ##2 rdata[21:20] == 2'h0)
    else $error("reserved bits not zero");
  a_store_version: assert property ($rose(req) && op == OP_STORE |-> ##2 rdata[19:17] == VERSION)
    else $error("version field wrong");
  a_store_tt: assert property ($rose(req) && op == OP_STORE |-> ##2 rdata[16:14] == $past(trap_type, 2))
    else $error("stored trap type differs");
  a_store_clears: assert property ($rose(req) && op == OP_STORE |-> ##3 trap_type == TT_NONE)
    else $error("trap type not cleared by store");
  a_load_keeps: assert property ($rose(req) && op == OP_LOAD |-> ##3 trap_type == $past(trap_type, 3))
    else $error("load changed trap type");
  a_tt_idle: assert property (!req |=> $stable(trap_type))
    else $error("trap type moved while idle");
  // Main scenarios seen on the link.
  c_trap: cover property (trap && trap_type == TT_STANDARD);
  c_mis: cover property (trap && trap_type == TT_MISALIGN);
  c_store: cover property (go && op == OP_STORE);
endmodule // fprf_chk

// ---- bench/tb_top.sv ----
// Testbench driving the controller over APB with the register block behind it.
`timescale 1ns/1ps
module tb_top;
  import fprf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        pready, pslverr, irq, nonstd_mode, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [1:0]  rnd_mode;
  int          n_fail, n_tests;
  fprf_if lnk();
  fprf_ctrl u_fprf_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .lnk(lnk.ctrl));
  fprf_dev u_fprf_dev(.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .rnd_mode(rnd_mode),
    .nonstd_mode(nonstd_mode));
  fprf_chk u_fprf_chk(.pclk(pclk), .presetn(presetn), .req(lnk.req), .op(lnk.op), .idx(lnk.idx),
    .ack(lnk.ack), .rdata(lnk.rdata), .trap(lnk.trap), .trap_type(lnk.trap_type));
  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error land in q and err.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one link command, wait for busy to clear, then fetch link read data.
  task cmd(input fprf_op_t o, input logic [4:0] i, input logic [4:0] e, input logic [1:0] c,
           input logic [31:0] d);
    int n;
    apb(1'b1, ADDR_WDATA, d);
    apb(1'b1, ADDR_CMD, {15'h0000, c, e, 1'b0, i, o});
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) n_fail++;
    st = q;
    apb(1'b0, ADDR_RDATA, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    for (int i = 0; i < 32; i++) cmd(OP_WR_S, i[4:0], 5'h0, 2'h0, {24'hA50000, i[7:0]});
    for (int i = 0; i < 32; i++) begin
      cmd(OP_RD_S, i[4:0], 5'h0, 2'h0, 32'h0);
      chk(q, {24'hA50000, i[7:0]});
    end
    cmd(OP_WR_D, 5'h02, 5'h0, 2'h0, 32'h11111111);
    cmd(OP_RD_S, 5'h02, 5'h0, 2'h0, 32'h0);
    chk(q, 32'h11111111);
    cmd(OP_WR_Q, 5'h08, 5'h0, 2'h0, 32'h22222222);
    cmd(OP_RD_S, 5'h08, 5'h0, 2'h0, 32'h0);
    chk(q, 32'h22222222);
    cmd(OP_RD_S, 5'h0B, 5'h0, 2'h0, 32'h0);
    chk(q, 32'h22222222);
    cmd(OP_WR_D, 5'h03, 5'h0, 2'h0, 32'h33333333);
    chk(st[2], 1'b1);
    cmd(OP_RD_S, 5'h03, 5'h0, 2'h0, 32'h0);
    chk(q, 32'h11111111);
    cmd(OP_WR_Q, 5'h06, 5'h0, 2'h0, 32'h44444444);
    chk(st[3:2], 2'h3);
  endtask
  // Load-state masks fixed fields; trap type from the last access survives it.
  task t_state;
    cmd(OP_LOAD, 5'h0, 5'h0, 2'h0, 32'hFFFFFFFF);
    chk(rnd_mode, 2'h3);
    chk(nonstd_mode, 1'b1);
    cmd(OP_STORE, 5'h0, 5'h0, 2'h0, 32'h0);
    chk(q, {2'h3, 2'h0, 5'h1F, 1'b1, 2'h0, VERSION, TT_MISALIGN, 2'h0, 2'h3, 5'h1F, 5'h1F});
    cmd(OP_STORE, 5'h0, 5'h0, 2'h0, 32'h0);
    chk(q[16:14], 3'h0);
    for (int k = 0; k < 4; k++) begin
      cmd(OP_LOAD, 5'h0, 5'h0, 2'h0, {k[1:0], 30'h0});
      chk(rnd_mode, k[1:0]);
    end
    chk(nonstd_mode, 1'b0);
  endtask
  // Only the enabled exception traps; interrupt follows the masked status.
  task t_fop;
    cmd(OP_LOAD, 5'h0, 5'h0, 2'h0, 32'h00800000);
    apb(1'b1, ADDR_MASK, 32'h2);
    apb(1'b0, ADDR_IRQ, 32'h0);
    cmd(OP_FOP, 5'h0, 5'h02, 2'h1, 32'h0);
    chk(st[2], 1'b0);
    chk(irq, 1'b0);
    cmd(OP_STORE, 5'h0, 5'h0, 2'h0, 32'h0);
    chk(q, {9'h001, 1'b0, 2'h0, VERSION, TT_NONE, 2'h0, 2'h1, 5'h02, 5'h02});
    cmd(OP_FOP, 5'h0, 5'h01, 2'h2, 32'h0);
    chk(st[2], 1'b1);
    chk(irq, 1'b1);
    cmd(OP_STORE, 5'h0, 5'h0, 2'h0, 32'h0);
    chk(q, {9'h001, 1'b0, 2'h0, VERSION, TT_STANDARD, 2'h0, 2'h1, 5'h02, 5'h01});
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk(q[1], 1'b1);
    #1;
    chk(irq, 1'b0);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(q, 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk({err, q}, 33'h100000000);
  endtask
  ////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: reset for six cycles, then the scenarios.
  initial begin
    n_fail = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(rnd_mode, 2'h0);
    t_regs();
    t_state();
    t_fop();
    summarize();
  end
  // Watchdog: the run needs about 1300 cycles, so this cuts a hang.
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule // tb_top
